//--- design/pcw_pkg.sv
// shared constants for the counter array pwm configuration block
// assumes an apb master with 8-bit byte addresses and 32-bit data
package pcw_pkg;
  localparam int ADDR_W = 8;
  localparam int NUM_CHAN = 3;
  localparam int CNT_W = 16;
  // register byte addresses
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_CHAN_MODE = 8'h20;
  localparam logic [7:0] ADDR_CMP_LO = 8'h30;
  localparam logic [7:0] ADDR_CMP_HI = 8'h34;
  localparam logic [7:0] CHAN_MODE_STEP = 8'h04;
  localparam logic [7:0] CMP_STEP = 8'h08;
  localparam logic [7:0] ADDR_PWM_CFG = 8'hf4;
  // array mode register fields
  localparam int MODE_CF_IE_BIT = 0;
  localparam int MODE_WDT_EN_BIT = 6;
  // array control register fields
  localparam int CTRL_RUN_BIT = 6;
  localparam int CTRL_CF_BIT = 7;
  // pwm cycle configuration fields
  localparam int CFG_RELOAD_BANK_SELECT_BIT = 7;
  localparam int CFG_CYCLE_OVERFLOW_IRQ_ENABLE_BIT = 6;
  localparam int CFG_CYCLE_OVERFLOW_FLAG_BIT = 5;
  localparam int CFG_CYCLE_LENGTH_SELECT_LSB = 0;
  // per channel mode fields
  localparam int CHMODE_PWM_BIT = 1;
  localparam int CHMODE_WIDE_BIT = 7;
  // interrupt status / mask fields
  localparam int IRQ_CF_BIT = 0;
  localparam int IRQ_COV_BIT = 1;
  // reset values and writable bit masks
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PWM_CFG_RST = 8'h00;
  localparam logic [7:0] CHMODE_RST = 8'h00;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [15:0] CMP_RST = 16'h0000;
  localparam logic [7:0] CFG_RW_MASK = 8'he3;
  localparam logic [7:0] MODE_RW_MASK = 8'h41;
  localparam logic [7:0] CHMODE_RW_MASK = 8'h82;

  typedef enum logic [1:0] {
    PCW_CLEN_8 = 2'h0,
    PCW_CLEN_9 = 2'h1,
    PCW_CLEN_10 = 2'h2,
    PCW_CLEN_11 = 2'h3
  } pcw_clen_t;
endpackage

//--- design/pcw_tmr_if.sv
// carrier between the main counter and the pwm channels
// assumes one instance inside the top module, single clock
`timescale 1ns/1ps
`default_nettype none
interface pcw_tmr_if;
  import pcw_pkg::*;
  logic [15:0] count;
  logic [15:0] cycMask;
  logic cycOvf;
  pcw_clen_t cycLen;
  logic run;
  modport ctr (input cycLen, input run, output count, output cycMask,
    output cycOvf);
  modport chan (input count, input cycMask, input cycOvf, input cycLen);
endinterface
`default_nettype wire

//--- design/pcw_counter.sv
// main array counter with full and cycle overflow detection
// assumes run and cycle length come from registers on sys_clk
`timescale 1ns/1ps
`default_nettype none
module pcw_counter
  import pcw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  pcw_tmr_if.ctr tmr,
  output logic fullOvf
);
  logic [15:0] count_q;

  // count one step per clock while running
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_q <= CMP_RST;
    end else if (tmr.run) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // cycle mask follows the length select
  always_comb begin
    case (tmr.cycLen)
      PCW_CLEN_8: tmr.cycMask = 16'h00ff;
      PCW_CLEN_9: tmr.cycMask = 16'h01ff;
      PCW_CLEN_10: tmr.cycMask = 16'h03ff;
      PCW_CLEN_11: tmr.cycMask = 16'h07ff; // see RULE13
      default: tmr.cycMask = 16'h00ff;
    endcase
  end

  // overflow pulses on the step that wraps the bits
  assign tmr.count = count_q;
  assign tmr.cycOvf = tmr.run &&
    ((count_q & tmr.cycMask) == tmr.cycMask); // see RULE7
  assign fullOvf = tmr.run && (count_q == 16'hffff);
endmodule
`default_nettype wire

//--- design/pcw_channel.sv
// one pwm channel: compare and auto-reload pairs plus pwm output
// assumes byte write strobes and a bank select from the top module
`timescale 1ns/1ps
`default_nettype none
module pcw_channel
  import pcw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  pcw_tmr_if.chan tmr,
  input wire logic wrLo,
  input wire logic wrHi,
  input wire logic bankSel,
  input wire logic [7:0] wrData,
  input wire logic pwmEn,
  input wire logic wideSel,
  output logic [7:0] rdLo,
  output logic [7:0] rdHi,
  output logic pwmOut
);
  logic [15:0] cmp_q;
  logic [15:0] reload_q;
  logic doReload;

  // reload only for 9..11 bit cycles of a narrow pwm channel
  assign doReload = tmr.cycOvf && pwmEn && !wideSel &&
    (tmr.cycLen != PCW_CLEN_8); // see RULE5 see RULE11

  // compare pair: bus writes land only with bank select low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmp_q <= CMP_RST;
    end else begin
      if (doReload) begin
        cmp_q <= reload_q; // see RULE5
      end
      if (wrLo && !bankSel) begin
        cmp_q[7:0] <= wrData; // see RULE4
      end
      if (wrHi && !bankSel) begin
        cmp_q[15:8] <= wrData;
      end
    end
  end

  // auto-reload pair: reached with bank select high
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reload_q <= CMP_RST;
    end else begin
      if (wrLo && bankSel) begin
        reload_q[7:0] <= wrData; // see RULE4
      end
      if (wrHi && bankSel) begin
        reload_q[15:8] <= wrData;
      end
    end
  end

  // read back through the selected bank
  assign rdLo = bankSel ? reload_q[7:0] : cmp_q[7:0];
  assign rdHi = bankSel ? reload_q[15:8] : cmp_q[15:8];

  // pwm level: wide mode full count, else masked cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwmOut <= 1'b0;
    end else if (!pwmEn) begin
      pwmOut <= 1'b0;
    end else if (wideSel) begin
      pwmOut <= tmr.count < cmp_q; // see RULE12
    end else begin
      pwmOut <= (tmr.count & tmr.cycMask) <
        (cmp_q & tmr.cycMask); // see RULE10 see RULE11
    end
  end
endmodule
`default_nettype wire

//--- design/pcw_top.sv
// register file, flags and interrupt for the counter array pwm setup
// assumes an apb master on sys_clk; pready is never held low
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// RULE1: bit 0 of the array mode register enables the counter overflow irq.
// RULE2: with that enable set the counter flag requests an irq, else never.
// RULE3: while watchdog enable is 1 the other mode bits ignore writes.
// RULE4: bank select bit 7 steers compare addresses to compare or reload.
// RULE5: reload values act only for 9, 10 and 11 bit pwm channels.
// RULE6: cycle irq enable bit 6 gates the cycle flag onto the array irq.
// RULE7: the cycle flag bit 5 sets when the counter wraps the selected bit.
// RULE8: the cycle flag is sticky, set by hardware or software, cleared by 0.
// RULE9: bits 4 to 2 of the pwm configuration read zero, writes dropped.
// RULE10: length select 00, 01, 10 give 8, 9 and 10 bit cycles.
// RULE11: the length applies to all narrow pwm channels, not 16-bit ones.
// RULE12: each wide select bit picks 8..11 bit when 0, 16-bit when 1.
// RULE13: length select 11 gives an 11 bit cycle.
// RULE14: the pwm configuration register resets to all zero.
module pcw_top
  import pcw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic arrayIrq,
  output logic [2:0] pwmOut
);
  // register state
  logic [7:0] mode_q;
  logic [7:0] ctrl_q;
  logic [7:0] cfg_q;
  logic [1:0] irqStat_q;
  logic [1:0] irqMask_q;
  logic [7:0] chMode_q [NUM_CHAN];
  logic [31:0] rdData_q;

  // bus decode helpers
  logic setup;
  logic access;
  logic wrEn;
  logic hit;
  logic [31:0] rdMux;
  logic [7:0] wByte;

  // channel side
  logic [NUM_CHAN-1:0] wrLo;
  logic [NUM_CHAN-1:0] wrHi;
  logic [7:0] chRdLo [NUM_CHAN];
  logic [7:0] chRdHi [NUM_CHAN];
  logic fullOvf;
  logic cfSet;
  logic covfSet;
  logic cfReq;
  logic covReq;
  logic [1:0] irqSet;
  logic [1:0] irqClr;

  pcw_tmr_if tmr ();

  // apb phases; the slave never waits
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign pready = 1'b1;
  assign wrEn = access && pwrite && hit;
  assign wByte = pwdata[7:0];
  assign pslverr = access && !hit;

  // address decode and read mux
  always_comb begin
    hit = 1'b1;
    rdMux = 32'h0000_0000;
    case (paddr)
      ADDR_MODE: rdMux[7:0] = mode_q;
      ADDR_CTRL: rdMux[7:0] = ctrl_q;
      ADDR_IRQ_STAT: rdMux[1:0] = irqStat_q;
      ADDR_IRQ_MASK: rdMux[1:0] = irqMask_q;
      ADDR_COUNT: rdMux[15:0] = tmr.count;
      ADDR_PWM_CFG: rdMux[7:0] = cfg_q & CFG_RW_MASK; // see RULE9
      default: hit = 1'b0;
    endcase
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (paddr == ADDR_CHAN_MODE + CHAN_MODE_STEP * 8'(i)) begin
        hit = 1'b1;
        rdMux[7:0] = chMode_q[i];
      end
      if (paddr == ADDR_CMP_LO + CMP_STEP * 8'(i)) begin
        hit = 1'b1;
        rdMux[7:0] = chRdLo[i]; // see RULE4
      end
      if (paddr == ADDR_CMP_HI + CMP_STEP * 8'(i)) begin
        hit = 1'b1;
        rdMux[7:0] = chRdHi[i]; // see RULE4
      end
    end
  end

  // read data captured in the setup cycle, shown in access
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdData_q <= 32'h0000_0000;
    end else if (setup) begin
      rdData_q <= rdMux;
    end
  end
  assign prdata = rdData_q;

  // array mode register with watchdog write lock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q <= MODE_RST;
    end else if (wrEn && paddr == ADDR_MODE) begin
      if (mode_q[MODE_WDT_EN_BIT]) begin
        mode_q[MODE_WDT_EN_BIT] <= wByte[MODE_WDT_EN_BIT]; // see RULE3
      end else begin
        mode_q <= wByte & MODE_RW_MASK; // see RULE1
      end
    end
  end

  // array control: run bit and sticky counter overflow flag
  assign cfSet = fullOvf;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
    end else begin
      if (wrEn && paddr == ADDR_CTRL) begin
        ctrl_q[CTRL_RUN_BIT] <= wByte[CTRL_RUN_BIT];
        ctrl_q[CTRL_CF_BIT] <= wByte[CTRL_CF_BIT] | cfSet;
      end else if (cfSet) begin
        ctrl_q[CTRL_CF_BIT] <= 1'b1;
      end
    end
  end

  // pwm cycle configuration; a hardware set beats a clear
  assign covfSet = tmr.cycOvf; // see RULE7
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_q <= PWM_CFG_RST; // see RULE14
    end else begin
      if (wrEn && paddr == ADDR_PWM_CFG) begin
        cfg_q <= (wByte & CFG_RW_MASK) |
          (8'(covfSet) << CFG_CYCLE_OVERFLOW_FLAG_BIT); // see RULE8 see RULE9
      end else if (covfSet) begin
        cfg_q[CFG_CYCLE_OVERFLOW_FLAG_BIT] <= 1'b1; // see RULE8
      end
    end
  end

  // length handed to the counter and channels, run to the counter only
  assign tmr.cycLen = pcw_clen_t'(cfg_q[CFG_CYCLE_LENGTH_SELECT_LSB +: 2]); // see RULE10
  assign tmr.run = ctrl_q[CTRL_RUN_BIT];

  // per channel mode bits
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        chMode_q[i] <= CHMODE_RST;
      end
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (wrEn && paddr == ADDR_CHAN_MODE + CHAN_MODE_STEP * 8'(i)) begin
          chMode_q[i] <= wByte & CHMODE_RW_MASK;
        end
      end
    end
  end

  // compare byte strobes per channel
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      wrLo[i] = wrEn && (paddr == ADDR_CMP_LO + CMP_STEP * 8'(i));
      wrHi[i] = wrEn && (paddr == ADDR_CMP_HI + CMP_STEP * 8'(i));
    end
  end

  // flag requests gated by their enables
  assign cfReq = ctrl_q[CTRL_CF_BIT] &&
    mode_q[MODE_CF_IE_BIT]; // see RULE2
  assign covReq = cfg_q[CFG_CYCLE_OVERFLOW_FLAG_BIT] &&
    cfg_q[CFG_CYCLE_OVERFLOW_IRQ_ENABLE_BIT]; // see RULE6
  assign irqSet = {covReq, cfReq};
  assign irqClr = (wrEn && paddr == ADDR_IRQ_STAT) ? wByte[1:0] : 2'h0;

  // sticky status, write one to clear, set wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqStat_q <= IRQ_RST;
    end else begin
      irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
    end
  end

  // interrupt mask
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqMask_q <= IRQ_RST;
    end else if (wrEn && paddr == ADDR_IRQ_MASK) begin
      irqMask_q <= wByte[1:0];
    end
  end

  // level interrupt while an unmasked status bit is set
  assign arrayIrq = |(irqStat_q & irqMask_q);

  // main counter
  pcw_counter u_counter (
    .sys_clk(sys_clk),
    .rst(rst),
    .tmr(tmr.ctr),
    .fullOvf(fullOvf)
  );

  // pwm channels share the cycle length
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    pcw_channel u_chan (
      .sys_clk(sys_clk),
      .rst(rst),
      .tmr(tmr.chan),
      .wrLo(wrLo[g]),
      .wrHi(wrHi[g]),
      .bankSel(cfg_q[CFG_RELOAD_BANK_SELECT_BIT]), // see RULE4
      .wrData(wByte),
      .pwmEn(chMode_q[g][CHMODE_PWM_BIT]),
      .wideSel(chMode_q[g][CHMODE_WIDE_BIT]), // see RULE12
      .rdLo(chRdLo[g]),
      .rdHi(chRdHi[g]),
      .pwmOut(pwmOut[g])
    );
  end
endmodule
`default_nettype wire

//--- bench/pcw_top_sva.sv
// port assertions for the pwm cycle configuration top
// assumes a bind onto pcw_top; apb writes commit at the access edge
`timescale 1ns/1ps
`default_nettype none
module pcw_top_sva
  import pcw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic arrayIrq,
  input wire logic [2:0] pwmOut
);
  logic [7:0] modeQ;
  logic [7:0] cfgQ;
  logic flagSeenQ;
  logic wrAcc;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  assign wrAcc = psel && penable && pwrite;
  // shadow of the mode register, locked bits kept
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      modeQ <= MODE_RST;
    end else if (wrAcc && paddr == ADDR_MODE) begin
      modeQ <= modeQ[6] ? {1'b0, pwdata[6], 5'h00, modeQ[0]}
                        : pwdata[7:0] & MODE_RW_MASK;
    end
  end
  // shadow of the software-only configuration bits
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfgQ <= PWM_CFG_RST;
    end else if (wrAcc && paddr == ADDR_PWM_CFG) begin
      cfgQ <= pwdata[7:0] & 8'hc3;
    end
  end
  // remembers a flag seen set until software writes the register
  always_ff @(posedge sys_clk) begin
    if (rst || (wrAcc && paddr == ADDR_PWM_CFG)) begin
      flagSeenQ <= 1'b0;
    end else if (psel && penable && !pwrite && paddr == ADDR_PWM_CFG) begin
      flagSeenQ <= flagSeenQ | prdata[5];
    end
  end
  sequence accRead(logic [7:0] a);
    psel && penable && !pwrite && paddr == a;
  endsequence
  sequence rdThenIdle;
    (psel && !penable && !pwrite) ##1 (psel && penable) ##1 !psel;
  endsequence
  cfg_unused_a: assert property (
    accRead(ADDR_PWM_CFG) |-> prdata[4:2] == 3'h0) else $error("unused bits");
  cfg_ctl_a: assert property (
    accRead(ADDR_PWM_CFG) |-> (prdata[7:0] & 8'hc3) == cfgQ)
    else $error("config readback");
  flag_sticky_a: assert property (
    accRead(ADDR_PWM_CFG) and flagSeenQ |-> prdata[5])
    else $error("flag lost");
  mode_lock_a: assert property (
    accRead(ADDR_MODE) |-> prdata[7:0] == modeQ) else $error("mode lock");
  irq_reset_a: assert property (
    $fell(rst) |-> !arrayIrq && prdata == 32'h0) else $error("reset state");
  read_upper_a: assert property (
    psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper bits");
  zero_wait_a: assert property (
    psel && penable |-> pready) else $error("wait state");
  err_phase_a: assert property (
    pslverr |-> psel && penable) else $error("stray error");
  read_stable_a: assert property (
    rdThenIdle |-> $stable(prdata)) else $error("read data moved");
endmodule
`default_nettype wire

//--- bench/pcw_cycle_setup_bench.sv
// bench for the pwm cycle configuration top: table, then hand tests
// assumes pcw_top with zero wait apb; checker bound at the foot
`timescale 1ns/1ps
`default_nettype none
module pcw_cycle_setup_bench;
  import pcw_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic arrayIrq;
  logic [2:0] pwmOut;
  logic [31:0] rd;
  logic err;
  int hiWide;
  int hiNarrow;
  int errorCnt = 0;
  int comparisons = 0;
  // address, write value, expected readback
  logic [23:0] rows [8] = '{24'hf4ffe3, 24'hf40000, 24'hf48181,
    24'hf44242, 24'h20ff82, 24'h0c0303, 24'h305a5a, 24'h3ca5a5};
  pcw_top i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .arrayIrq(arrayIrq), .pwmOut(pwmOut));
  // 40 mhz clock
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic reportAndStop();
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // level interrupt looked at mid-cycle, once registers have settled
  task automatic checkIrq(input logic exp);
    @(negedge sys_clk);
    check({31'h0, arrayIrq}, {31'h0, exp});
    @(posedge sys_clk);
  endtask
  // high cycles of channels 0 and 1 over one 512 cycle window
  task automatic countHigh(output int h0, output int h1);
    h0 = 0;
    h1 = 0;
    repeat (512) begin
      @(negedge sys_clk);
      if (pwmOut[0] === 1'b1) begin
        h0++;
      end
      if (pwmOut[1] === 1'b1) begin
        h1++;
      end
    end
    @(posedge sys_clk);
  endtask
  // one apb transfer, bounded wait on pready, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 16) begin
        errorCnt++;
        reportAndStop();
      end
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, ADDR_PWM_CFG, 32'h0);
    check(rd, 32'h0);
    // table of write then read back
    foreach (rows[i]) begin
      apb(1'b1, rows[i][23:16], {24'h0, rows[i][15:8]});
      apb(1'b0, rows[i][23:16], 32'h0);
      check(rd, {24'h0, rows[i][7:0]});
    end
    apb(1'b0, 8'hfc, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    // compare addresses steered by the bank select
    apb(1'b1, ADDR_PWM_CFG, 32'h0);
    apb(1'b1, ADDR_CMP_LO, 32'h11);
    apb(1'b1, ADDR_PWM_CFG, 32'h80);
    apb(1'b1, ADDR_CMP_LO, 32'h22);
    apb(1'b0, ADDR_CMP_LO, 32'h0);
    check(rd, 32'h22);
    apb(1'b1, ADDR_PWM_CFG, 32'h0);
    apb(1'b0, ADDR_CMP_LO, 32'h0);
    check(rd, 32'h11);
    // watchdog enable freezes the other mode bits
    apb(1'b1, ADDR_MODE, 32'h41);
    apb(1'b1, ADDR_MODE, 32'h0);
    apb(1'b0, ADDR_MODE, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, ADDR_MODE, 32'h0);
    apb(1'b0, ADDR_MODE, 32'h0);
    check(rd, 32'h0);
    // cycle flag timing for each length, then irq gating and clear
    for (int c = 0; c < 4; c++) begin
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      apb(1'b1, ADDR_IRQ_MASK, 32'h2);
      apb(1'b1, ADDR_PWM_CFG, 32'(c));
      apb(1'b1, ADDR_CTRL, 32'h40);
      repeat ((256 << c) - 30) @(posedge sys_clk);
      apb(1'b0, ADDR_PWM_CFG, 32'h0);
      check(rd, 32'(c));
      repeat (40) @(posedge sys_clk);
      apb(1'b0, ADDR_PWM_CFG, 32'h0);
      check(rd, 32'(c) | 32'h20);
      apb(1'b0, ADDR_PWM_CFG, 32'h0);
      check(rd, 32'(c) | 32'h20);
      checkIrq(1'b0);
      apb(1'b1, ADDR_PWM_CFG, 32'(c) | 32'h60);
      checkIrq(1'b1);
      apb(1'b1, ADDR_PWM_CFG, 32'(c));
      apb(1'b1, ADDR_IRQ_STAT, 32'h2);
      checkIrq(1'b0);
      apb(1'b0, ADDR_PWM_CFG, 32'h0);
      check(rd, 32'(c));
    end
    // reload feeds the narrow channel; the wide one keeps the full count
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b1, ADDR_PWM_CFG, 32'h81);
    apb(1'b1, ADDR_CMP_LO + CMP_STEP, 32'h40);
    apb(1'b1, ADDR_PWM_CFG, 32'h01);
    apb(1'b1, ADDR_CMP_LO, 32'h40);
    apb(1'b1, ADDR_CHAN_MODE, 32'h82);
    apb(1'b1, ADDR_CHAN_MODE + CHAN_MODE_STEP, 32'h02);
    apb(1'b1, ADDR_CTRL, 32'h40);
    repeat (520) @(posedge sys_clk);
    countHigh(hiWide, hiNarrow);
    check(32'(hiNarrow), 32'h40);
    check(32'(hiWide), 32'h0);
    // counter overflow flag and its interrupt enable
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b1, ADDR_MODE, 32'h01);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h40);
    repeat (65530) @(posedge sys_clk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h40);
    repeat (8) @(posedge sys_clk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'hc0);
    checkIrq(1'b1);
    apb(1'b1, ADDR_MODE, 32'h0);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1);
    checkIrq(1'b0);
    reportAndStop();
  end
endmodule
bind pcw_top pcw_top_sva i_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .arrayIrq(arrayIrq), .pwmOut(pwmOut));
`default_nettype wire
